/* hw/mie_regs.svh */
// Purpose: Register offsets, field positions and reset values of the executor
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef MIE_REGS_SVH
`define MIE_REGS_SVH

// Byte offsets
`define MIE_CMD_OFF    8'h00
`define MIE_STAT_OFF   8'h04
`define MIE_WREG_OFF   8'h08
`define MIE_IMM_OFF    8'h0c
`define MIE_TABLE_POINTER_OFF   8'h10
`define MIE_TABLE_HIGH_LATCH_OFF   8'h14
`define MIE_MADDR_OFF  8'h18
`define MIE_MDATA_OFF  8'h1c
`define MIE_PAGE_OFF   8'h20

// Command word fields
`define MIE_CMD_OP_LSB   0
`define MIE_CMD_BIT_LSB  8
`define MIE_CMD_ADR_LSB  16

// Status word bits
`define MIE_ST_BUSY   0
`define MIE_ST_SKIP   1
`define MIE_ST_C      2
`define MIE_ST_AC     3
`define MIE_ST_Z      4
`define MIE_ST_OV     5
`define MIE_ST_ILL    6
`define MIE_ST_CYC    8

// Reset values and the all-ones byte written by set_byte
`define MIE_WREG_RST  8'h00
`define MIE_FLAG_RST  1'b0
`define MIE_ALL_ONES  8'hff

`endif

/* hw/mie_pkg.sv */
// Purpose: Types used by the executor: opcodes and sequencer states
// Assumes: Nothing beyond the constants header
// Notes:   Opcode codes are the command-word encoding
package mie_pkg;

  // Operation codes written into the command register
  typedef enum logic [4:0] {
    decrement_skip_to_working  = 5'h00,
    set_byte                   = 5'h01,
    set_bit                    = 5'h02,
    increment_skip_in_place    = 5'h03,
    increment_skip_to_working  = 5'h04,
    bit_set_skip               = 5'h05,
    subtract_working           = 5'h06,
    subtract_to_memory         = 5'h07,
    subtract_immediate         = 5'h08,
    nibble_exchange            = 5'h09,
    nibble_exchange_to_working = 5'h0a,
    zero_test_skip             = 5'h0b,
    copy_zero_skip             = 5'h0c,
    bit_clear_skip             = 5'h0d,
    current_page_table_read    = 5'h0e,
    last_page_table_read       = 5'h0f,
    xor_working                = 5'h10,
    xor_into_memory            = 5'h11,
    xor_immediate              = 5'h12
  } mie_op_e;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_READ  = 7'h02,
    ST_EXEC  = 7'h04,
    ST_DUMMY = 7'h08,
    ST_TREAD = 7'h10,
    ST_TLOAD = 7'h20,
    ST_MLOAD = 7'h40
  } mie_fsm_e;

endpackage : mie_pkg

/* hw/mie_mem_if.sv */
// Purpose: Port between the executor and its data memory
// Assumes: Single clock, read data one cycle after re
// Notes:   Write and read never issued together
`timescale 1ns/1ps
interface mie_mem_if #(parameter int AW = 6) ();
  logic [AW-1:0] addr;
  logic          re;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport master (output addr, re, we, wdata, input rdata);
  modport slave  (input addr, re, we, wdata, output rdata);
endinterface : mie_mem_if

/* hw/mie_dmem.sv */
// Purpose: Byte-wide data memory with registered read port
// Assumes: One access per cycle from the executor
// Notes:   Contents clear to zero on reset
`timescale 1ns/1ps
module mie_dmem #(
  parameter int AW = 6
) (
  input  wire logic pclk,
  input  wire logic presetn,
  mie_mem_if.slave  bus
);
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            rdata;
  } mie_dmem_s;

  mie_dmem_s r;
  mie_dmem_s next_r;

  // Read data leave a flop so the executor sees a clean value
  always_comb
  begin
    next_r = r;
    if (bus.we)
    begin
      next_r.mem[bus.addr] = bus.wdata;
    end
    if (bus.re)
    begin
      next_r.rdata = r.mem[bus.addr];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign bus.rdata = r.rdata;
endmodule : mie_dmem

/* hw/mie_exec.sv */
// Purpose: Executes skip, set, subtract, swap, table-read and XOR operations
// Assumes: Program memory answers one cycle after prog_rd on the same clock
// Notes:   One command at a time; APB writes are ignored while busy
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "mie_regs.svh"

// How it works
// [RULE1] Decrement to working register, skip on zero
// [RULE2] Byte set writes all ones, flags kept
// [RULE3] Bit set forces chosen bit, flags kept
// [RULE4] Increment in place, skip on zero
// [RULE5] Increment to working register, skip on zero
// [RULE6] Skip inserts one dummy cycle
// [RULE7] Skip when selected bit is one
// [RULE8] Subtract byte into working, four flags
// [RULE9] No-borrow flag clear only when negative
// [RULE10] Subtract result written back to memory
// [RULE11] Subtract immediate into working, four flags
// [RULE12] Nibble swap in place, flags kept
// [RULE13] Nibble swap into working, memory kept
// [RULE14] Skip when byte is zero, nothing changed
// [RULE15] Copy to working, skip on zero
// [RULE16] Skip when selected bit is zero
// [RULE17] Current-page table read to memory and latch
// [RULE18] Last-page table read, absent on smallest part
// [RULE19] XOR byte into working, zero flag only
// [RULE20] XOR written back to memory, zero flag only
// [RULE21] XOR immediate into working, zero flag only
// [RULE22] Zero flag set when result is zero
// [RULE23] Byte arithmetic wraps modulo 256
module mie_exec #(
  parameter int DMEM_AW       = 6,
  parameter int PROG_AW       = 11,
  parameter int PW            = 16,
  parameter bit HAS_LAST_PAGE = 1'b1
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic      [PROG_AW-1:0] prog_addr,
  output logic                    prog_rd,
  input  wire logic [PW-1:0]      prog_rdata,
  output logic                    busy,
  output logic                    skip_dummy
);
  localparam int PGW = PROG_AW - 8;

  typedef struct packed {
    mie_pkg::mie_fsm_e    state;
    mie_pkg::mie_op_e     op;
    logic [7:0]           addr;
    logic [2:0]           bsel;
    logic [7:0]           wreg;
    logic [7:0]           imm;
    logic [7:0]           table_pointer;
    logic [PW-9:0]        table_high_latch;
    logic [PGW-1:0]       page;
    logic [7:0]           maddr;
    logic [7:0]           mdata;
    logic                 fc;
    logic                 fac;
    logic                 fz;
    logic                 fov;
    logic                 skip;
    logic                 ill;
    logic [1:0]           cyc;
    logic [PROG_AW-1:0]   paddr_q;
    logic                 prd;
    logic [31:0]          rdata;
    logic                 err;
  } mie_state_s;

  mie_state_s r;
  mie_state_s next_r;

  mie_mem_if #(.AW(DMEM_AW)) mif ();

  mie_dmem #(.AW(DMEM_AW)) u_dmem (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (mif.master)
  );

  // Bus phases; registers answer with no wait state
  logic       setup;
  logic       wacc;
  logic       idle;
  logic [7:0] m;
  logic [7:0] sub_b;
  logic [8:0] diff;
  logic [4:0] dlo;
  logic [7:0] inc;
  logic [7:0] dec;
  logic [7:0] xo;
  logic [7:0] swp;
  logic       mbit;
  logic       mwe;
  logic [7:0] mwad;
  logic [7:0] mwd;
  logic       take;

  assign setup = psel & ~penable;
  assign wacc  = psel & penable & pwrite;
  assign idle  = (r.state == mie_pkg::ST_IDLE);

  // Datapath terms, results taken as 8 bits so they wrap
  assign m     = mif.rdata;
  assign sub_b = (r.op == mie_pkg::subtract_immediate) ? r.imm : m; // [RULE11]
  assign diff  = {1'b0, r.wreg} - {1'b0, sub_b};
  assign dlo   = {1'b0, r.wreg[3:0]} - {1'b0, sub_b[3:0]};
  assign inc   = m + 8'h01; // [RULE23]
  assign dec   = m - 8'h01; // [RULE23]
  assign xo    = r.wreg ^ ((r.op == mie_pkg::xor_immediate) ? r.imm : m); // [RULE21]
  assign swp   = {m[3:0], m[7:4]};
  assign mbit  = m[r.bsel];

  // Next-state logic of the whole sequencer and register file
  always_comb
  begin
    next_r    = r;
    mif.addr  = r.addr[DMEM_AW-1:0];
    mif.re    = 1'b0;
    mwe       = 1'b0;
    mwad      = r.addr;
    mwd       = 8'h00;
    take      = 1'b0;

    // Read data and error are caught in setup so they come from flops
    if (setup)
    begin
      next_r.err   = 1'b0;
      next_r.rdata = 32'h0000_0000;
      if (paddr == `MIE_CMD_OFF)
      begin
        next_r.rdata[4:0]   = r.op;
        next_r.rdata[10:8]  = r.bsel;
        next_r.rdata[23:16] = r.addr;
      end
      else if (paddr == `MIE_STAT_OFF)
      begin
        next_r.rdata[`MIE_ST_BUSY]      = ~idle;
        next_r.rdata[`MIE_ST_SKIP]      = r.skip;
        next_r.rdata[`MIE_ST_C]         = r.fc;
        next_r.rdata[`MIE_ST_AC]        = r.fac;
        next_r.rdata[`MIE_ST_Z]         = r.fz;
        next_r.rdata[`MIE_ST_OV]        = r.fov;
        next_r.rdata[`MIE_ST_ILL]       = r.ill;
        next_r.rdata[`MIE_ST_CYC +: 2]  = r.cyc;
      end
      else if (paddr == `MIE_WREG_OFF)
      begin
        next_r.rdata[7:0] = r.wreg;
      end
      else if (paddr == `MIE_IMM_OFF)
      begin
        next_r.rdata[7:0] = r.imm;
      end
      else if (paddr == `MIE_TABLE_POINTER_OFF)
      begin
        next_r.rdata[7:0] = r.table_pointer;
      end
      else if (paddr == `MIE_TABLE_HIGH_LATCH_OFF)
      begin
        next_r.rdata[PW-9:0] = r.table_high_latch;
      end
      else if (paddr == `MIE_MADDR_OFF)
      begin
        next_r.rdata[7:0] = r.maddr;
      end
      else if (paddr == `MIE_MDATA_OFF)
      begin
        next_r.rdata[7:0] = r.mdata;
      end
      else if (paddr == `MIE_PAGE_OFF)
      begin
        next_r.rdata[PGW-1:0] = r.page;
      end
      else
      begin
        next_r.err = 1'b1;
      end
    end

    // Writes only land while idle, so operands cannot shift mid-operation
    if (wacc && idle)
    begin
      if (paddr == `MIE_CMD_OFF)
      begin
        next_r.op   = mie_pkg::mie_op_e'(pwdata[`MIE_CMD_OP_LSB +: 5]);
        next_r.bsel = pwdata[`MIE_CMD_BIT_LSB +: 3];
        next_r.addr = pwdata[`MIE_CMD_ADR_LSB +: 8];
        next_r.skip = 1'b0;
        next_r.ill  = 1'b0;
        next_r.cyc  = 2'h1;
        take        = 1'b1;
      end
      else if (paddr == `MIE_STAT_OFF)
      begin
        next_r.fc  = pwdata[`MIE_ST_C];
        next_r.fac = pwdata[`MIE_ST_AC];
        next_r.fz  = pwdata[`MIE_ST_Z];
        next_r.fov = pwdata[`MIE_ST_OV];
      end
      else if (paddr == `MIE_WREG_OFF)
      begin
        next_r.wreg = pwdata[7:0];
      end
      else if (paddr == `MIE_IMM_OFF)
      begin
        next_r.imm = pwdata[7:0];
      end
      else if (paddr == `MIE_TABLE_POINTER_OFF)
      begin
        next_r.table_pointer = pwdata[7:0];
      end
      else if (paddr == `MIE_MADDR_OFF)
      begin
        // Fetch the byte now; the data register loads it in the ST_MLOAD cycle that follows
        next_r.maddr = pwdata[7:0];
        mif.addr     = pwdata[DMEM_AW-1:0];
        mif.re       = 1'b1;
        next_r.state = mie_pkg::ST_MLOAD;
      end
      else if (paddr == `MIE_MDATA_OFF)
      begin
        next_r.mdata = pwdata[7:0];
        mwe          = 1'b1;
        mwad         = r.maddr;
        mwd          = pwdata[7:0];
      end
      else if (paddr == `MIE_PAGE_OFF)
      begin
        next_r.page = pwdata[PGW-1:0];
      end
    end

    // Launch a command
    if (take)
    begin
      if (next_r.op == mie_pkg::current_page_table_read)
      begin
        next_r.paddr_q = {r.page, r.table_pointer}; // [RULE17]
        next_r.prd     = 1'b1;
        next_r.state   = mie_pkg::ST_TREAD;
      end
      else if (next_r.op == mie_pkg::last_page_table_read)
      begin
        if (HAS_LAST_PAGE)
        begin
          next_r.paddr_q = {{PGW{1'b1}}, r.table_pointer}; // [RULE18]
          next_r.prd     = 1'b1;
          next_r.state   = mie_pkg::ST_TREAD;
        end
        else
        begin
          next_r.ill = 1'b1; // [RULE18]
        end
      end
      else if (next_r.op > mie_pkg::xor_immediate)
      begin
        next_r.ill = 1'b1;
      end
      else
      begin
        next_r.state = mie_pkg::ST_READ;
      end
    end

    case (r.state)
      mie_pkg::ST_READ:
      begin
        mif.re       = 1'b1;
        next_r.state = mie_pkg::ST_EXEC;
      end
      mie_pkg::ST_EXEC:
      begin
        mwad = r.addr;
        case (r.op)
          mie_pkg::decrement_skip_to_working:
          begin
            next_r.wreg = dec; // [RULE1]
            next_r.skip = (dec == 8'h00); // [RULE1]
          end
          mie_pkg::set_byte:
          begin
            mwe = 1'b1;
            mwd = `MIE_ALL_ONES; // [RULE2]
          end
          mie_pkg::set_bit:
          begin
            mwe = 1'b1;
            mwd = m | (8'h01 << r.bsel); // [RULE3]
          end
          mie_pkg::increment_skip_in_place:
          begin
            mwe         = 1'b1;
            mwd         = inc; // [RULE4]
            next_r.skip = (inc == 8'h00); // [RULE4]
          end
          mie_pkg::increment_skip_to_working:
          begin
            next_r.wreg = inc; // [RULE5]
            next_r.skip = (inc == 8'h00); // [RULE5]
          end
          mie_pkg::bit_set_skip:
          begin
            next_r.skip = mbit; // [RULE7]
          end
          mie_pkg::bit_clear_skip:
          begin
            next_r.skip = ~mbit; // [RULE16]
          end
          mie_pkg::subtract_working, mie_pkg::subtract_immediate:
          begin
            next_r.wreg = diff[7:0]; // [RULE8] [RULE11]
          end
          mie_pkg::subtract_to_memory:
          begin
            mwe = 1'b1;
            mwd = diff[7:0]; // [RULE10]
          end
          mie_pkg::nibble_exchange:
          begin
            mwe = 1'b1;
            mwd = swp; // [RULE12]
          end
          mie_pkg::nibble_exchange_to_working:
          begin
            next_r.wreg = swp; // [RULE13]
          end
          mie_pkg::zero_test_skip:
          begin
            next_r.skip = (m == 8'h00); // [RULE14]
          end
          mie_pkg::copy_zero_skip:
          begin
            next_r.wreg = m; // [RULE15]
            next_r.skip = (m == 8'h00); // [RULE15]
          end
          mie_pkg::xor_working, mie_pkg::xor_immediate:
          begin
            next_r.wreg = xo; // [RULE19] [RULE21]
            next_r.fz   = (xo == 8'h00); // [RULE22]
          end
          mie_pkg::xor_into_memory:
          begin
            mwe       = 1'b1;
            mwd       = xo; // [RULE20]
            next_r.fz = (xo == 8'h00); // [RULE22]
          end
          default:
          begin
            next_r.ill = 1'b1;
          end
        endcase
        // All three subtracts share the flag update
        if (r.op == mie_pkg::subtract_working || r.op == mie_pkg::subtract_immediate ||
            r.op == mie_pkg::subtract_to_memory)
        begin
          next_r.fc  = ~diff[8]; // [RULE9]
          next_r.fac = ~dlo[4]; // [RULE8]
          next_r.fov = (r.wreg[7] ^ sub_b[7]) & (r.wreg[7] ^ diff[7]); // [RULE8]
          next_r.fz  = (diff[7:0] == 8'h00); // [RULE22]
        end
        // A taken skip costs a second cycle
        if (next_r.skip)
        begin
          next_r.cyc   = 2'h2; // [RULE6]
          next_r.state = mie_pkg::ST_DUMMY; // [RULE6]
        end
        else
        begin
          next_r.state = mie_pkg::ST_IDLE;
        end
      end
      mie_pkg::ST_DUMMY:
      begin
        next_r.state = mie_pkg::ST_IDLE; // [RULE6]
      end
      mie_pkg::ST_TREAD:
      begin
        next_r.prd   = 1'b0;
        next_r.state = mie_pkg::ST_TLOAD;
      end
      mie_pkg::ST_TLOAD:
      begin
        mwe          = 1'b1;
        mwd          = prog_rdata[7:0]; // [RULE17] [RULE18]
        next_r.table_high_latch  = prog_rdata[PW-1:8]; // [RULE17] [RULE18]
        next_r.state = mie_pkg::ST_IDLE;
      end
      mie_pkg::ST_MLOAD:
      begin
        next_r.mdata = m;
        next_r.state = mie_pkg::ST_IDLE;
      end
      default:
      begin
      end
    endcase

    // Keep the data window coherent with writes from the executor
    if (mwe && mwad == r.maddr)
    begin
      next_r.mdata = mwd;
    end
    mif.we    = mwe;
    mif.wdata = mwd;
    if (mwe)
    begin
      mif.addr = mwad[DMEM_AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r       <= '0;
      r.state <= mie_pkg::ST_IDLE;
      r.op    <= mie_pkg::decrement_skip_to_working;
      r.wreg  <= `MIE_WREG_RST;
      r.fc    <= `MIE_FLAG_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from state flops, except pready tied high
  assign prdata     = r.rdata;
  assign pready     = 1'b1;
  assign pslverr    = r.err;
  assign prog_addr  = r.paddr_q;
  assign prog_rd    = r.prd;
  assign busy       = ~idle;
  assign skip_dummy = (r.state == mie_pkg::ST_DUMMY);
endmodule : mie_exec

/* tb/mie_exec_assertions.sv */
// Purpose: Temporal checks on the executor's ports
// Assumes: Zero-wait APB slave, opcodes as in mie_pkg
// Notes:   Sees ports only; bound into every mie_exec
`timescale 1ns/1ps
module mie_exec_checker #(
  parameter int PROG_AW = 11,
  parameter int PW      = 16
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [PROG_AW-1:0] prog_addr,
  input wire logic               prog_rd,
  input wire logic [PW-1:0]      prog_rdata,
  input wire logic               busy,
  input wire logic               skip_dummy
);
  // Command write that the idle executor must accept
  logic cmd_wr;
  assign cmd_wr = psel && penable && pwrite && (paddr == 8'h00) && !busy;

  default clocking chk_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answers: zero wait, error only outside the map
  a_ready_always: assert property (penable |-> pready)
    else $error("pready low in an access cycle");
  a_unmapped_err: assert property (psel && !penable && paddr[1:0] == 2'b00
    |=> pslverr == ($past(paddr) > 8'h20)) else $error("pslverr disagrees with map");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h20
    |=> prdata == 32'h0) else $error("unmapped read not zero");
  a_stat_busy: assert property (psel && !penable && !pwrite && paddr == 8'h04
    |=> prdata[0] == $past(busy)) else $error("status busy bit differs from busy");
  // Skip timing: one dummy cycle after two busy cycles
  a_dummy_one_cycle: assert property (skip_dummy |-> busy ##1 (!busy && !skip_dummy))
    else $error("dummy cycle not exactly one cycle");
  a_dummy_after_exec: assert property (skip_dummy |-> $past(busy, 1) && $past(busy, 2))
    else $error("dummy cycle without execution");
  a_cmd_goes_busy: assert property (cmd_wr && pwdata[4:0] <= 5'h12 |=> busy)
    else $error("legal command did not start");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("operation longer than two cycles plus dummy");
  // Table reads: one fetch pulse, last page on all-ones page bits
  a_prog_rd_pulse: assert property (prog_rd |=> !prog_rd)
    else $error("fetch strobe longer than one cycle");
  a_table_fetch: assert property (cmd_wr && pwdata[4:1] == 4'h7 |=> prog_rd)
    else $error("table read did not fetch");
  a_last_page_addr: assert property (cmd_wr && pwdata[4:0] == 5'h0f
    |=> prog_rd && (&prog_addr[PROG_AW-1:8])) else $error("last page not addressed");
  a_prog_addr_held: assert property ($changed(prog_addr) |-> prog_rd)
    else $error("program address moved without a fetch");
endmodule : mie_exec_checker

bind mie_exec mie_exec_checker #(.PROG_AW(PROG_AW), .PW(PW)) mie_exec_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata), .busy(busy),
  .skip_dummy(skip_dummy)
);

/* tb/testbench.sv */
// Purpose: Self-checking bench for the executor over APB
// Assumes: Zero-wait APB, program memory modelled here
// Notes:   Table of plain cases, then hand-written awkward ones
`timescale 1ns/1ps
`include "mie_regs.svh"
module testbench;
  // Flags are packed {ov, z, ac, c} as in status bits 5:2
  typedef struct {
    logic [4:0] op;
    logic [2:0] bt;
    logic [7:0] w;
    logic [7:0] m;
    logic [7:0] imm;
    logic [3:0] fl;
    logic [7:0] ew;
    logic [7:0] em;
    logic       sk;
    logic [3:0] ef;
  } mie_row_s;

  mie_row_s rows [25] = '{
    '{5'h00,3'h0,8'h55,8'h01,8'h00,4'ha,8'h00,8'h01,1'b1,4'ha},
    '{5'h00,3'h0,8'h55,8'h00,8'h00,4'ha,8'hff,8'h00,1'b0,4'ha},
    '{5'h01,3'h0,8'h33,8'h12,8'h00,4'h5,8'h33,8'hff,1'b0,4'h5},
    '{5'h02,3'h5,8'h33,8'h81,8'h00,4'ha,8'h33,8'ha1,1'b0,4'ha},
    '{5'h03,3'h0,8'h33,8'hff,8'h00,4'ha,8'h33,8'h00,1'b1,4'ha},
    '{5'h03,3'h0,8'h33,8'h7f,8'h00,4'h5,8'h33,8'h80,1'b0,4'h5},
    '{5'h04,3'h0,8'h33,8'hff,8'h00,4'h5,8'h00,8'hff,1'b1,4'h5},
    '{5'h04,3'h0,8'h33,8'h10,8'h00,4'h5,8'h11,8'h10,1'b0,4'h5},
    '{5'h05,3'h3,8'h33,8'h08,8'h00,4'ha,8'h33,8'h08,1'b1,4'ha},
    '{5'h05,3'h3,8'h33,8'hf7,8'h00,4'ha,8'h33,8'hf7,1'b0,4'ha},
    '{5'h06,3'h0,8'h05,8'h07,8'h00,4'hf,8'hfe,8'h07,1'b0,4'h0},
    '{5'h06,3'h0,8'h07,8'h07,8'h00,4'h0,8'h00,8'h07,1'b0,4'h7},
    '{5'h07,3'h0,8'h80,8'h01,8'h00,4'h0,8'h80,8'h7f,1'b0,4'h9},
    '{5'h08,3'h0,8'h3a,8'haa,8'h5b,4'hf,8'hdf,8'haa,1'b0,4'h0},
    '{5'h09,3'h0,8'h33,8'ha5,8'h00,4'ha,8'h33,8'h5a,1'b0,4'ha},
    '{5'h0a,3'h0,8'h33,8'h3c,8'h00,4'h5,8'hc3,8'h3c,1'b0,4'h5},
    '{5'h0b,3'h0,8'h33,8'h00,8'h00,4'ha,8'h33,8'h00,1'b1,4'ha},
    '{5'h0b,3'h0,8'h33,8'h01,8'h00,4'h5,8'h33,8'h01,1'b0,4'h5},
    '{5'h0c,3'h0,8'h33,8'h00,8'h00,4'ha,8'h00,8'h00,1'b1,4'ha},
    '{5'h0c,3'h0,8'h33,8'h9e,8'h00,4'ha,8'h9e,8'h9e,1'b0,4'ha},
    '{5'h0d,3'h0,8'h33,8'hfe,8'h00,4'ha,8'h33,8'hfe,1'b1,4'ha},
    '{5'h0d,3'h7,8'h33,8'h80,8'h00,4'ha,8'h33,8'h80,1'b0,4'ha},
    '{5'h10,3'h0,8'h5a,8'h5a,8'h00,4'ha,8'h00,8'h5a,1'b0,4'he},
    '{5'h11,3'h0,8'h3c,8'hc3,8'h00,4'hf,8'h3c,8'hff,1'b0,4'hb},
    '{5'h12,3'h0,8'hc3,8'h55,8'hc3,4'h1,8'h00,8'h55,1'b0,4'h5}
  };

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] prog_rdata = 16'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, prog_rd, busy, skip_dummy;
  logic [10:0] prog_addr;
  logic [10:0] last_fetch = 11'h0;
  int          fails = 0;
  int          comparisons = 0;
  int          dummies = 0;

  mie_exec mie_exec_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata), .busy(busy),
    .skip_dummy(skip_dummy)
  );

  always #5 pclk = ~pclk;

  // Program word pattern: high byte from address bits 10:3, low byte inverted
  function automatic logic [15:0] pword(input logic [10:0] a);
    return {a[10:3], ~a[7:0]};
  endfunction : pword

  // Program memory answers next cycle, toggles when not addressed
  always @(posedge pclk)
  begin
    if (prog_rd === 1'b1)
    begin
      prog_rdata <= pword(prog_addr);
      last_fetch <= prog_addr;
    end
    else
      prog_rdata <= ~prog_rdata;
    if (skip_dummy === 1'b1)
      dummies <= dummies + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // One APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    @(posedge pclk);
    for (int k = 0; k < 16 && busy !== 1'b0; k++)
      @(posedge pclk);
    check({31'h0, busy}, 32'h0, "busy cleared");
  endtask : wait_idle

  task automatic set_mem(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `MIE_MADDR_OFF, {24'h0, a}, r, e);
    wait_idle();
    apb(1'b1, `MIE_MDATA_OFF, {24'h0, d}, r, e);
  endtask : set_mem

  task automatic get_mem(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b1, `MIE_MADDR_OFF, {24'h0, a}, r, e);
    wait_idle();
    apb(1'b0, `MIE_MDATA_OFF, 32'h0, r, e);
  endtask : get_mem

  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] a);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `MIE_CMD_OFF, {8'h0, a, 5'h0, b, 3'h0, op}, r, e);
    wait_idle();
  endtask : run

  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic [15:0] pw;
    logic [10:0] pa;
    logic        e;
    int          n0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `MIE_STAT_OFF, 32'h0, r, e);
    check(r, 32'h0, "status after reset");
    apb(1'b0, `MIE_WREG_OFF, 32'h0, r, e);
    check(r, 32'h0, "working after reset");
    $display("reset test done");
    foreach (rows[i])
    begin
      set_mem(8'h08 + 8'(i), rows[i].m);
      apb(1'b1, `MIE_WREG_OFF, {24'h0, rows[i].w}, r, e);
      apb(1'b1, `MIE_IMM_OFF, {24'h0, rows[i].imm}, r, e);
      apb(1'b1, `MIE_STAT_OFF, {26'h0, rows[i].fl, 2'b00}, r, e);
      n0 = dummies;
      run(rows[i].op, rows[i].bt, 8'h08 + 8'(i));
      apb(1'b0, `MIE_WREG_OFF, 32'h0, r, e);
      check(r, {24'h0, rows[i].ew}, "working");
      apb(1'b0, `MIE_STAT_OFF, 32'h0, r, e);
      check({25'h0, r[9:8], r[5:1]}, {25'h0, (rows[i].sk ? 2'h2 : 2'h1), rows[i].ef,
            rows[i].sk}, "status");
      check(32'(dummies - n0), {31'h0, rows[i].sk}, "dummy cycles");
      get_mem(8'h08 + 8'(i), r);
      check(r, {24'h0, rows[i].em}, "memory");
      $display("row %0d done", i);
    end
    // Table reads from current page and last page
    for (int k = 0; k < 2; k++)
    begin
      pa = {((k == 0) ? 3'h5 : 3'h7), 8'h9c + 8'(k)};
      pw = pword(pa);
      apb(1'b1, `MIE_PAGE_OFF, 32'h5, r, e);
      apb(1'b1, `MIE_TABLE_POINTER_OFF, {24'h0, pa[7:0]}, r, e);
      run(5'h0e + 5'(k), 3'h0, 8'h30 + 8'(k));
      check({21'h0, last_fetch}, {21'h0, pa}, "fetch address");
      get_mem(8'h30 + 8'(k), r);
      check(r, {24'h0, pw[7:0]}, "table low byte");
      apb(1'b0, `MIE_TABLE_HIGH_LATCH_OFF, 32'h0, r, e);
      check(r, {24'h0, pw[15:8]}, "table high latch");
      $display("table test %0d done", k);
    end
    // Unmapped read and write, then an illegal opcode
    apb(1'b0, 8'h40, 32'h0, r, e);
    check({r[31:1], e}, 32'h1, "unmapped read");
    apb(1'b1, 8'h24, 32'hffffffff, r, e);
    check({31'h0, e}, 32'h1, "unmapped write");
    run(5'h13, 3'h0, 8'h08);
    apb(1'b0, `MIE_STAT_OFF, 32'h0, r, e);
    check({31'h0, r[6]}, 32'h1, "illegal flag");
    $display("refusal tests done");
    // Write landing in the dummy cycle must be ignored
    set_mem(8'h3a, 8'h01);
    apb(1'b1, `MIE_CMD_OFF, {8'h0, 8'h3a, 16'h0000}, r, e);
    apb(1'b1, `MIE_WREG_OFF, 32'h77, r, e);
    wait_idle();
    apb(1'b0, `MIE_WREG_OFF, 32'h0, r, e);
    check(r, 32'h0, "write while busy");
    $display("busy test done");
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (6000) @(posedge pclk);
    fails++;
    tally_and_finish();
  end
endmodule : testbench
